// file: rtl/usep_port.sv
// user sense/enable port: sticky sense flags and enable pin drivers
`timescale 1ns/1ps
module usep_port
#(
    parameter bit DUAL_PATH = 1'b1
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire usep_pkg::usep_bus_req_t bus_req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    input wire logic [2:0] sense_in_i,
    output logic [2:0] drive_out_o
);
    import usep_pkg::*;

    // the pair that exists only on the dual-path variant
    localparam int PAIR_DUAL_ONLY = USEP_PAIRS - 1;

    // stored register image and the value it takes at the next edge
    usep_user_reg_t user_reg;
    usep_user_reg_t next_user_reg;
    // read answer flops
    logic [USEP_DW-1:0] rdata;
    logic [USEP_DW-1:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    // enable pin flops
    logic [USEP_PAIRS-1:0] drive_out;
    logic [USEP_PAIRS-1:0] next_drive_out;
    // per-pair sense path
    logic [USEP_PAIRS-1:0] sense_hit;
    logic [USEP_PAIRS-1:0] pair_live;
    logic [USEP_PAIRS-1:0] flag_now;
    logic [USEP_PAIRS-1:0] flag_keep;
    logic [USEP_PAIRS-1:0] next_flag;
    // bus decode
    logic wr_hit;
    logic rd_hit;

    // true when a bus request addresses this register
    function automatic logic reg_hit(input usep_bus_req_t req);
        return req.addr == USEP_ADDR_USER;
    endfunction

    // a pair works unless it is the dual-path-only pair on a single-path part
    function automatic logic pair_enabled(input int pair);
        return (pair != PAIR_DUAL_ONLY) || DUAL_PATH;
    endfunction

    // register bit that holds the sense flag of a pair
    function automatic int sense_pos(input int pair);
        int pos;
        pos = USEP_POS_SENSE_0;
        if (pair == 1)
        begin
            pos = USEP_POS_SENSE_1;
        end
        else if (pair == PAIR_DUAL_ONLY)
        begin
            pos = USEP_POS_SENSE_2;
        end
        return pos;
    endfunction

    // register bit that holds the drive control of a pair
    function automatic int drive_pos(input int pair);
        int pos;
        pos = USEP_POS_DRIVE_0;
        if (pair == 1)
        begin
            pos = USEP_POS_DRIVE_1;
        end
        else if (pair == PAIR_DUAL_ONLY)
        begin
            pos = USEP_POS_DRIVE_2;
        end
        return pos;
    endfunction

    // read image: bits of a pair without function read as zero; the stored
    // value stays, so software sees no ghost state on single-path parts
    function automatic logic [USEP_DW-1:0] read_view(input usep_user_reg_t r);
        logic [USEP_DW-1:0] v;
        int i;
        v = r;
        for (i = 0; i < USEP_PAIRS; i++)
        begin
            v[sense_pos(i)] = r[sense_pos(i)] & pair_enabled(i);
            v[drive_pos(i)] = r[drive_pos(i)] & pair_enabled(i);
        end
        return v;
    endfunction

    // pin levels: each drive bit sets its own pin, dead pairs held low
    function automatic logic [USEP_PAIRS-1:0] pin_view(input usep_user_reg_t r);
        logic [USEP_PAIRS-1:0] p;
        int i;
        p = '0;
        for (i = 0; i < USEP_PAIRS; i++)
        begin
            p[i] = r[drive_pos(i)] & pair_enabled(i);
        end
        return p;
    endfunction

    // one synchroniser, qualifier and sticky flag update per sense pair
    genvar gi;
    generate
        for (gi = 0; gi < USEP_PAIRS; gi++)
        begin : g_pair
            // the pin must pass the qualifier before it may touch the flag
            usep_sense_qual u_qual
            (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .sense_in_i(sense_in_i[gi]),
                .hit_o(sense_hit[gi])
            );
            // pair 2 has no function on single-path parts
            assign pair_live[gi] = pair_enabled(gi);
            // a write of 0 clears the flag, a write of 1 leaves it alone
            assign flag_now[gi] = user_reg[sense_pos(gi)];
            assign flag_keep[gi] = !wr_hit || bus_req_i.wdata[sense_pos(gi)];
            // set beats clear so an event in the write cycle is never lost
            assign next_flag[gi] = (sense_hit[gi] & pair_live[gi])
                | (flag_now[gi] & flag_keep[gi]);
        end
    endgenerate

    // address decode shared by the write and read paths
    assign wr_hit = reg_hit(bus_req_i) & bus_req_i.wr;
    assign rd_hit = reg_hit(bus_req_i) & bus_req_i.rd;

    // register next value: drive and reserved bits take the written data,
    // sense flags come from the per-pair set and clear logic
    always_comb
    begin
        next_user_reg = user_reg;
        if (wr_hit)
        begin
            next_user_reg.drive_ctl_0 = bus_req_i.wdata[USEP_POS_DRIVE_0];
            next_user_reg.drive_ctl_1 = bus_req_i.wdata[USEP_POS_DRIVE_1];
            next_user_reg.drive_ctl_2 = bus_req_i.wdata[USEP_POS_DRIVE_2];
            // reserved bits are plain storage that reads back what was written
            next_user_reg.reserved_bit_5 = bus_req_i.wdata[USEP_POS_RES_5];
            next_user_reg.reserved_bit_7 = bus_req_i.wdata[USEP_POS_RES_7];
        end
        next_user_reg.sense_flag_0 = next_flag[0];
        next_user_reg.sense_flag_1 = next_flag[1];
        next_user_reg.sense_flag_2 = next_flag[2];
    end

    // register storage; reset clears every bit including the reserved ones
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            user_reg <= USEP_RESET_VALUE;
        end
        else
        begin
            user_reg <= next_user_reg;
        end
    end

    // pins follow the drive bits as they stand after this edge, so a write
    // reaches the pins in the same cycle as it reaches the register
    always_comb
    begin
        next_drive_out = pin_view(next_user_reg);
    end

    // pin flops; every pin is low from reset until software drives it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            drive_out <= '0;
        end
        else
        begin
            drive_out <= next_drive_out;
        end
    end

    // read answer: one-cycle pulse; data is zero when no read was answered,
    // and a read beside a write returns the value from before the write
    always_comb
    begin
        next_rvalid = rd_hit;
        next_rdata = '0;
        if (rd_hit)
        begin
            next_rdata = read_view(user_reg);
        end
    end

    // read answer flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata <= '0;
            rvalid <= 1'b0;
        end
        else
        begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // every output comes straight from a flop
    assign rdata_o = rdata;
    assign rvalid_o = rvalid;
    assign drive_out_o = drive_out;

endmodule // usep_port

// file: pkg/usep_pkg.sv
// package: register layout, offsets, reset values and qualify timing of the user sense/enable port
package usep_pkg;

    // register address on the management control bus
    localparam logic [7:0] USEP_ADDR_USER = 8'h17;

    // register width and number of sense/enable pairs
    localparam int USEP_DW = 8;
    localparam int USEP_PAIRS = 3;

    // bit positions inside the user register
    localparam int USEP_POS_SENSE_0 = 0;
    localparam int USEP_POS_SENSE_1 = 1;
    localparam int USEP_POS_DRIVE_0 = 2;
    localparam int USEP_POS_DRIVE_1 = 3;
    localparam int USEP_POS_SENSE_2 = 4;
    localparam int USEP_POS_RES_5 = 5;
    localparam int USEP_POS_DRIVE_2 = 6;
    localparam int USEP_POS_RES_7 = 7;

    // reset value of the whole register
    localparam logic [7:0] USEP_RESET_VALUE = 8'h00;

    // clock rate and the least time a sense pin must stay high
    localparam int USEP_CLK_PERIOD_PS = 4000;
    localparam int USEP_QUAL_TIME_NS = 40;
    // least time rounds up to whole cycles, never below one
    localparam int USEP_QUAL_RAW =
        (USEP_QUAL_TIME_NS * 1000 + USEP_CLK_PERIOD_PS - 1) / USEP_CLK_PERIOD_PS;
    localparam int USEP_QUAL_CYCLES = (USEP_QUAL_RAW < 1) ? 1 : USEP_QUAL_RAW;
    localparam int USEP_QUAL_W = $clog2(USEP_QUAL_CYCLES + 1);

    // register image, most significant field first
    typedef struct packed {
        logic reserved_bit_7;
        logic drive_ctl_2;
        logic reserved_bit_5;
        logic sense_flag_2;
        logic drive_ctl_1;
        logic drive_ctl_0;
        logic sense_flag_1;
        logic sense_flag_0;
    } usep_user_reg_t;

    // one register access from the control bus
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } usep_bus_req_t;

endpackage

// file: rtl/usep_sense_qual.sv
// sense pin synchroniser and consecutive-high qualifier
`timescale 1ns/1ps
module usep_sense_qual
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sense_in_i,
    output logic hit_o
);
    import usep_pkg::*;

    logic sync_a;
    logic sync_b;
    logic [USEP_QUAL_W-1:0] run_cnt;
    logic hit;
    logic next_sync_a;
    logic next_sync_b;
    logic [USEP_QUAL_W-1:0] next_run_cnt;
    logic next_hit;

    localparam logic [USEP_QUAL_W-1:0] QUAL_LAST = USEP_QUAL_W'(USEP_QUAL_CYCLES);
    localparam logic [USEP_QUAL_W-1:0] CNT_ZERO = '0;
    localparam logic [USEP_QUAL_W-1:0] CNT_ONE = USEP_QUAL_W'(1);

    // count consecutive high samples; pulse once when the run reaches the threshold
    always_comb
    begin
        next_sync_a = sense_in_i;
        next_sync_b = sync_a; // first stage feeds only this flop
        next_run_cnt = run_cnt;
        next_hit = 1'b0;
        if (!sync_b)
        begin
            next_run_cnt = CNT_ZERO; // any low sample restarts the run
        end
        else if (run_cnt != QUAL_LAST)
        begin
            next_run_cnt = run_cnt + CNT_ONE;
            next_hit = (run_cnt + CNT_ONE) == QUAL_LAST;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            run_cnt <= CNT_ZERO;
            hit <= 1'b0;
        end
        else
        begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
            run_cnt <= next_run_cnt;
            hit <= next_hit;
        end
    end

    assign hit_o = hit;

endmodule // usep_sense_qual

// file: verification/usep_sense_model.sv
// partner model: external logic that raises sense pins and loads enable pins
`timescale 1ns/1ps
module usep_sense_model
(
    input wire logic clk_i,
    input wire logic [2:0] drive_out_i,
    output logic [2:0] sense_in_o
);
    initial sense_in_o = 3'h0;

    // raise chosen pins for n cycles; edges land on falling clock edges
    task automatic pulse(input logic [2:0] pins, input int n);
        @(negedge clk_i);
        sense_in_o = pins;
        repeat (n) @(negedge clk_i);
        sense_in_o = 3'h0;
    endtask
endmodule // usep_sense_model

// file: verification/usep_port_checker.sv
// checker: register bus and pin assertions for the user sense/enable port
`timescale 1ns/1ps
module usep_port_checker
#(
    parameter bit DUAL_PATH = 1'b1
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire usep_pkg::usep_bus_req_t bus_req_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic [2:0] sense_in_i,
    input wire logic [2:0] drive_out_o
);
    import usep_pkg::*;
    logic sel;
    // only this address reaches the register
    assign sel = bus_req_i.addr == USEP_ADDR_USER;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a flag read set with no write around it, then a plain read right behind it
    sequence flag_read(int b);
        rvalid_o && rdata_o[b] && !bus_req_i.wr && !$past(bus_req_i.wr)
            ##1 sel && bus_req_i.rd && !bus_req_i.wr;
    endsequence
    rd_answer_a: assert property (sel && bus_req_i.rd |=> rvalid_o) else $error("no read answer");
    idle_quiet_a: assert property (!(sel && bus_req_i.rd) |=> !rvalid_o && rdata_o == 8'h00)
        else $error("answer without read");
    drive_write_a: assert property (sel && bus_req_i.wr |=> drive_out_o ==
        {DUAL_PATH && $past(bus_req_i.wdata[6]), $past(bus_req_i.wdata[3]),
        $past(bus_req_i.wdata[2])}) else $error("drive pins differ from write");
    drive_hold_a: assert property (!(sel && bus_req_i.wr) |=> $stable(drive_out_o))
        else $error("drive pins moved");
    reset_clear_a: assert property (disable iff (1'b0) rst_i |=>
        rdata_o == 8'h00 && !rvalid_o && drive_out_o == 3'h0) else $error("reset left state");
    flag2_sticky_a: assert property (flag_read(4) |=> rvalid_o && rdata_o[4])
        else $error("flag 2 lost");
    flag0_sticky_a: assert property (flag_read(0) |=> rvalid_o && rdata_o[0])
        else $error("flag 0 lost");
    read_drive_a: assert property (rvalid_o && !$past(bus_req_i.wr) |->
        {rdata_o[6], rdata_o[3], rdata_o[2]} == drive_out_o) else $error("read vs pins");
endmodule // usep_port_checker

bind usep_port usep_port_checker #(.DUAL_PATH(DUAL_PATH)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .bus_req_i(bus_req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .sense_in_i(sense_in_i),
    .drive_out_o(drive_out_o));

// file: verification/user_sense_enable_port_bench.sv
// testbench: register, drive pin and sticky sense checks of the port
`timescale 1ns/1ps
module user_sense_enable_port_bench;
    import usep_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    usep_bus_req_t req = '0;
    logic [7:0] rdata_o;
    logic rvalid_o;
    logic [2:0] sense;
    logic [2:0] drive;
    logic [7:0] rdata_s;
    logic rvalid_s;
    logic [2:0] drive_s;
    int fails = 0;
    int checks_done = 0;
    always #2 clk_i = ~clk_i;
    usep_port dut (.clk_i(clk_i), .rst_i(rst_i), .bus_req_i(req), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .sense_in_i(sense), .drive_out_o(drive));
    // single-path variant on the same bus and sense pins
    usep_port #(.DUAL_PATH(1'b0)) dut_single (.clk_i(clk_i), .rst_i(rst_i), .bus_req_i(req),
        .rdata_o(rdata_s), .rvalid_o(rvalid_s), .sense_in_i(sense), .drive_out_o(drive_s));
    usep_sense_model m (.clk_i(clk_i), .drive_out_i(drive), .sense_in_o(sense));
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{a, 1'b1, 1'b0, d};
        @(negedge clk_i);
        req = '0;
        @(negedge clk_i);
    endtask
    // n back-to-back reads of both variants, each answer looked at one cycle on;
    // the dual-path answer must be gone again in the cycle after the last read
    task automatic rd(input logic [7:0] e, input logic [7:0] es, input int n);
        req = '{USEP_ADDR_USER, 1'b0, 1'b1, 8'h00};
        repeat (n)
        begin
            @(negedge clk_i);
            chk("rdata", rdata_o, e);
            chk("rdata_single", rdata_s, es);
            chk("rvalid", {7'h0, rvalid_o}, 8'h01);
            chk("rvalid_single", {7'h0, rvalid_s}, 8'h01);
        end
        req = '0;
        @(negedge clk_i);
        chk("rvalid_idle", {7'h0, rvalid_o}, 8'h00);
        chk("rdata_idle", rdata_o, 8'h00);
    endtask
    task automatic t_drive();
        wr(USEP_ADDR_USER, 8'hcc);
        chk("drive", {5'h0, drive}, 8'h07);
        chk("drive_single", {5'h0, drive_s}, 8'h03);
        rd(8'hcc, 8'h8c, 1);
        wr(8'h16, 8'h00);
        chk("drive", {5'h0, drive}, 8'h07);
        wr(USEP_ADDR_USER, 8'h08);
        chk("drive", {5'h0, drive}, 8'h02);
        rst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        rd(8'h00, 8'h00, 1);
        chk("drive", {5'h0, drive}, 8'h00);
        chk("drive_single", {5'h0, drive_s}, 8'h00);
    endtask
    task automatic t_sense();
        m.pulse(3'b101, 15);
        repeat (6) @(negedge clk_i);
        rd(8'h11, 8'h01, 3);
        wr(USEP_ADDR_USER, 8'h00);
        rd(8'h00, 8'h00, 1);
        m.pulse(3'b010, 8);
        repeat (15) @(negedge clk_i);
        rd(8'h00, 8'h00, 1);
        m.pulse(3'b010, 10);
        repeat (6) @(negedge clk_i);
        rd(8'h02, 8'h02, 1);
    endtask
    task automatic wrap_up();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence after three reset cycles
    initial
    begin
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        rd(8'h00, 8'h00, 1);
        t_drive();
        t_sense();
        wrap_up();
    end
    // tests need under a hundred cycles; cut a hang well beyond that
    initial
    begin
        #20000;
        fails++;
        wrap_up();
    end
endmodule // user_sense_enable_port_bench
